// *** bench/cfg_host_model.sv ***
// host model that clocks 16-bit command frames into the port
`timescale 1ns/1ps
module cfg_host_model (
	input  wire logic        clock,
	output logic             cs_n,
	output logic             sclk,
	output logic             din,
	input  wire logic        dout,
	output logic [15:0]      reply,
	output logic             reply_stb
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b1;
		reply = 16'h0000;
		reply_stb = 1'b0;
	end

	// one frame msb first; 8-clock phases stay clear of the pin synchroniser
	task automatic frame(input logic [15:0] w, input int n);
		logic [15:0] r;
		r = 16'h0000;
		@(posedge clock);
		cs_n <= 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			@(posedge clock);
			din <= w[i];
			repeat (8) @(posedge clock);
			r[i] = dout;
			sclk <= 1'b1;
			repeat (8) @(posedge clock);
			sclk <= 1'b0;
		end
		repeat (8) @(posedge clock);
		cs_n <= 1'b1;
		din <= ~din; // idle data line carries no stale level
		// short frames give nothing worth reporting
		if (n == 16) begin
			reply <= r;
			reply_stb <= 1'b1;
		end
		@(posedge clock);
		reply_stb <= 1'b0;
		repeat (10) @(posedge clock);
	endtask

	// select low with the serial clock idle, for the test drive
	task automatic hold(input int cyc);
		@(posedge clock);
		cs_n <= 1'b0;
		repeat (cyc) @(posedge clock);
		cs_n <= 1'b1;
		repeat (10) @(posedge clock);
	endtask
endmodule // cfg_host_model

// *** bench/uart_config_readback_port_tb_top.sv ***
// self-checking bench for the configuration and read-back port
`timescale 1ns/1ps
module uart_config_readback_port_tb_top;
	logic        clock, reset_n, cs_n, sclk, din, dout, dout_oe;
	logic        tx_busy, tx_line_in, rts_n_in, tx_pin, rts_n_pin, irq, cfg_clear;
	logic        fifo_off, sleep_state, infrared_sel, two_stop_sel, parity_on;
	logic        short_word_sel, test_mode, reply_stb, rts_prev;
	logic [3:0]  divisor_code, irq_mask, src;
	logic [13:0] applied;
	logic [15:0] reply;
	logic [15:0] exp_q[$];
	logic [31:0] seed;
	int          n_fail, checked, n_clr, nw, n_tog, n_txh;

	assign applied = {fifo_off, sleep_state, irq_mask, infrared_sel, two_stop_sel,
		parity_on, short_word_sel, divisor_code};

	uart_config_port #(.OSC_HALF_CYCLES(7'h01)) i_uart_config_port (
		.clock(clock), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk), .din(din),
		.dout(dout), .dout_oe(dout_oe), .rx_ready_flag(src[2]), .tx_empty_flag(src[3]),
		.tx_busy(tx_busy), .parity_seen(src[1]), .rxact_ferr(src[0]),
		.tx_line_in(tx_line_in), .rts_n_in(rts_n_in), .tx_pin(tx_pin),
		.rts_n_pin(rts_n_pin), .irq(irq), .cfg_clear(cfg_clear), .fifo_off(fifo_off),
		.sleep_state(sleep_state), .infrared_sel(infrared_sel),
		.two_stop_sel(two_stop_sel), .parity_on(parity_on),
		.short_word_sel(short_word_sel), .divisor_code(divisor_code),
		.irq_mask(irq_mask), .test_mode(test_mode)
	);

	cfg_host_model i_cfg_host_model (
		.clock(clock), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
		.reply(reply), .reply_stb(reply_stb)
	);

	always #2.5 clock = ~clock;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// flags are noted after the sources have settled, then the frame goes out
	task automatic wr(input logic [13:0] cfg);
		@(posedge clock);
		exp_q.push_back({src[2], src[3], 14'h0000});
		nw++;
		i_cfg_host_model.frame({2'h3, cfg}, 16);
		repeat (4) @(posedge clock);
	endtask

	task automatic rd(input logic [13:0] cfg, input logic t);
		@(posedge clock);
		exp_q.push_back({src[2], src[3], cfg});
		i_cfg_host_model.frame({2'h1, 13'h0000, t}, 16);
	endtask

	// every reply is matched against the oldest note
	always @(posedge clock) begin
		if (reply_stb === 1'b1) begin
			// output still enabled: select rise needs a few clocks to be seen
			chk(dout_oe, 1'b1);
			if (exp_q.size() > 0)
				chk(reply, exp_q.pop_front());
			else
				chk(reply, 16'hxxxx);
		end
	end

	// clear pulses are counted to match them against accepted writes
	always @(posedge clock) begin
		if (cfg_clear === 1'b1)
			n_clr <= n_clr + 1;
	end

	// hang guard
	initial begin
		repeat (60000) @(posedge clock);
		chk(16'h0000, 16'h0001);
		print_verdict();
	end

	initial begin
		clock = 1'b0;
		reset_n = 1'b0;
		src = 4'h0;
		tx_busy = 1'b0;
		tx_line_in = 1'b1;
		rts_n_in = 1'b1;
		seed = 32'hc107c7e1;
		n_fail = 0;
		checked = 0;
		n_clr = 0;
		nw = 0;
		repeat (10) @(posedge clock);
		reset_n <= 1'b1;
		repeat (8) @(posedge clock);
		wr(14'h080a);
		chk(applied, 14'h080a);
		// random settings and sources, each written then read back
		for (int k = 0; k < 6; k++) begin
			seed = xs(seed);
			@(posedge clock);
			{rts_n_in, tx_line_in, src} <= seed[21:16];
			wr(seed[13:0]);
			chk(applied, seed[13:0]);
			chk(irq, |(seed[11:8] & src));
			chk(tx_pin, tx_line_in);
			chk(dout_oe, 1'b0);
			rd(seed[13:0], 1'b0);
		end
		// each mask alone, against its own source and against all others
		for (int m = 0; m < 4; m++) begin
			@(posedge clock);
			src <= 4'hf ^ (4'h1 << m);
			wr({2'h0, 4'h1 << m, 8'h00});
			chk(irq, 1'b0);
			@(posedge clock);
			src <= 4'h1 << m;
			repeat (4) @(posedge clock);
			chk(irq, 1'b1);
		end
		// masks act at once, the rest waits for the transmission to end
		@(posedge clock);
		tx_busy <= 1'b1;
		wr(14'h0f35);
		chk(applied, 14'h0f00);
		rd(14'h0f35, 1'b0);
		tx_busy <= 1'b0;
		repeat (4) @(posedge clock);
		chk(applied, 14'h0f35);
		i_cfg_host_model.frame(16'hffff, 15);
		chk(applied, 14'h0f35);
		// a data command is not ours: flags plus zeros come back, nothing changes
		exp_q.push_back({src[2], src[3], 14'h0000});
		i_cfg_host_model.frame(16'hbfff, 16);
		chk(applied, 14'h0f35);
		// test drive on and then off, divisor ratio 2 gives a 2-clock half period
		wr(14'h0001);
		@(posedge clock);
		tx_line_in <= 1'b1;
		rts_n_in <= 1'b1;
		for (int t = 1; t >= 0; t--) begin
			rd(14'h0001, t[0]);
			chk(test_mode, t[0]);
			fork
				i_cfg_host_model.hold(60);
				begin
					repeat (12) @(posedge clock);
					n_tog = 0;
					n_txh = 0;
					rts_prev = rts_n_pin;
					repeat (40) begin
						@(posedge clock);
						n_tog += (rts_n_pin !== rts_prev);
						rts_prev = rts_n_pin;
						n_txh += (tx_pin !== 1'b0);
					end
				end
			join
			chk(t ? (n_tog >= 19 && n_tog <= 21) : (n_tog == 0), 1'b1);
			chk(n_txh, t ? 0 : 40);
		end
		chk(n_clr, nw);
		// every noted reply must have come back
		chk(exp_q.size(), 0);
		print_verdict();
	end
endmodule // uart_config_readback_port_tb_top

// *** common/uart_cfg_pkg.sv ***
// constants for the serial configuration and read-back port of the uart
// Summary of operation
// [R1] bit 11 enables the transmit-buffer-empty interrupt source
// [R2] bit 10 enables the receive-data-available interrupt source
// [R3] bit 9 enables the received-parity-bit interrupt source
// [R4] bit 8 enables receive-activity or framing-error interrupt source
// [R5] bit 4 selects 7-bit words, else 8-bit words; parity adds one
// [R6] configuration write replies ready and empty flags, then 14 zeros
// [R7] host may use the two flags but ignores the trailing zeros
// [R8] host waits for oscillator, then writes and reads back until match
// [R9] read-back command is 0,1 on top bits; bit 0 is test select
// [R10] read-back returns last written setup; bit 12 shows sleep state
// [R11] reply bit 15 is set while received data is waiting
// [R12] reply bit 14 is set while the transmit buffer is empty
// [R13] bit 13 set bypasses the receive fifo
// [R14] read-back bit 12 is set while software shutdown is in force
// [R15] bit 7 selects infrared pulse timing instead of normal timing
// [R16] bit 6 selects two stop bits, else one
// [R17] bit 5 enables parity on transmit and receive
// [R18] bits 3 to 0 pick the baud divisor from the oscillator
// [R19] read-back with bit 0 set enters test mode, clear leaves it
// [R20] test mode with select low drives handshake output at 16x baud
// [R21] test mode with select low holds the transmit output low
// [R22] configuration write is 1,1 on top bits, setup in bits 13..0
// [R23] mask bits act after 16th rising edge, others after transmission
// [R24] configuration write clears fifo, flags and holding bits
// [R25] a command counts only when select rises after exactly 16 edges; mask bits still load at the 16th edge even if more edges follow
// [R26] interrupt is the or of the four masked sources
package uart_cfg_pkg;
	localparam int          WORD_W         = 16;
	localparam logic [4:0]  FRAME_BITS     = 5'h10;
	localparam logic [4:0]  CMD_BITS       = 5'h02;
	localparam logic [3:0]  LAST_FALL      = 4'he;
	localparam logic [1:0]  CMD_WRITE_CFG  = 2'h3;
	localparam logic [1:0]  CMD_READ_CFG   = 2'h1;
	localparam int          CMD_HI         = 15;
	localparam int          RX_READY_BIT   = 15;
	localparam int          TX_EMPTY_BIT   = 14;
	localparam int          FIFO_OFF_BIT   = 13;
	localparam int          SLEEP_BIT      = 12;
	localparam int          MASK_HI        = 11;
	localparam int          MASK_LO        = 8;
	localparam int          IR_BIT         = 7;
	localparam int          STOP2_BIT      = 6;
	localparam int          PARITY_ON_BIT  = 5;
	localparam int          SHORT_BIT      = 4;
	localparam int          DIV_HI         = 3;
	localparam int          TEST_BIT       = 0;
	localparam logic [13:0] CFG_RESET      = 14'h0000;
	localparam logic [3:0]  MASK_RESET     = 4'h0;
	// pin order inside the synchroniser bank: select, serial clock, data
	localparam int          PIN_CS         = 0;
	localparam int          PIN_SCLK       = 1;
	localparam int          PIN_DIN        = 2;
	localparam logic [2:0]  PIN_IDLE       = 3'h1;
	// oscillator stand-in, the 16x baud clock is oscillator over divisor
	localparam int          CLOCK_KHZ      = 200000;
	localparam int          OSC_KHZ        = 3686;
	localparam int          OSC_HALF_CYCLES = CLOCK_KHZ / (2 * OSC_KHZ);
endpackage

// *** hw/baud_tick_gen.sv ***
// 16x baud clock generator driven by the divisor code
`timescale 1ns/1ps
module baud_tick_gen #(
	parameter logic [6:0] HALF_CYCLES = 7'h1b
) (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic [3:0] divisor_code,
	output logic            baud16
);
	logic [15:0] count_q;
	logic [15:0] limit;
	logic [8:0]  ratio;

	// divisor table: low three bits pick a power of two, bit 3 adds x3
	always_comb begin
		ratio = 9'h001 << divisor_code[2:0]; // see [R18]
		if (divisor_code[3]) begin
			ratio = 9'((ratio << 1) + ratio);
		end
		// widen before the product: ratio 384 times the half period overflows nine bits
		limit = 16'(ratio) * 16'(HALF_CYCLES) - 16'h0001;
	end

	// toggle every half period of the 16x clock
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= 16'h0000;
			baud16  <= 1'b0;
		end else if (count_q >= limit) begin
			count_q <= 16'h0000;
			baud16  <= ~baud16;
		end else begin
			count_q <= count_q + 16'h0001;
		end
	end
endmodule // baud_tick_gen

// *** hw/uart_config_port.sv ***
// serial configuration write, read-back and test mode of the uart
`timescale 1ns/1ps
module uart_config_port #(
	parameter logic [6:0] OSC_HALF_CYCLES = 7'(uart_cfg_pkg::OSC_HALF_CYCLES)
) (
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic       cs_n,
	input  wire logic       sclk,
	input  wire logic       din,
	output logic            dout,
	output logic            dout_oe,
	input  wire logic       rx_ready_flag,
	input  wire logic       tx_empty_flag,
	input  wire logic       tx_busy,
	input  wire logic       parity_seen,
	input  wire logic       rxact_ferr,
	input  wire logic       tx_line_in,
	input  wire logic       rts_n_in,
	output logic            tx_pin,
	output logic            rts_n_pin,
	output logic            irq,
	output logic            cfg_clear,
	output logic            fifo_off,
	output logic            sleep_state,
	output logic            infrared_sel,
	output logic            two_stop_sel,
	output logic            parity_on,
	output logic            short_word_sel,
	output logic [3:0]      divisor_code,
	output logic [3:0]      irq_mask,
	output logic            test_mode
);
	logic [1:0]  rst_sync_q;
	logic        rst_n;
	logic [2:0]  pin_q [3];
	logic [2:0]  filt_q;
	logic [2:0]  filt_d;
	logic        cs_fall;
	logic        cs_rise;
	logic        sclk_rise;
	logic        sclk_fall;
	logic [4:0]  bit_cnt_q;
	logic [3:0]  fall_cnt_q;
	logic [15:0] shift_q;
	logic [15:0] word_in;
	logic [15:0] frame_q;
	logic [15:0] reply_q;
	logic [13:0] cfg_q;
	logic [13:0] pend_q;
	logic        pend_valid_q;
	logic [13:0] readback;
	logic [3:0]  sources;
	logic        baud16;
	logic        test_drive;

	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// three-flop synchronisers; a level counts once stages two and three agree
	for (genvar i = 0; i < 3; i++) begin : g_pin
		logic pin_raw;
		assign pin_raw = (i == uart_cfg_pkg::PIN_CS) ? cs_n :
				 (i == uart_cfg_pkg::PIN_SCLK) ? sclk : din;
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				pin_q[i] <= {3{uart_cfg_pkg::PIN_IDLE[i]}};
				filt_q[i] <= uart_cfg_pkg::PIN_IDLE[i];
			end else begin
				pin_q[i] <= {pin_q[i][1:0], pin_raw};
				filt_q[i] <= filt_d[i];
			end
		end
		assign filt_d[i] = (pin_q[i][1] == pin_q[i][2]) ? pin_q[i][2] : filt_q[i];
	end

	// edges of the filtered levels; clock edges count only inside a frame
	assign cs_fall   = filt_q[uart_cfg_pkg::PIN_CS] & ~filt_d[uart_cfg_pkg::PIN_CS];
	assign cs_rise   = ~filt_q[uart_cfg_pkg::PIN_CS] & filt_d[uart_cfg_pkg::PIN_CS];
	assign sclk_rise = ~filt_q[uart_cfg_pkg::PIN_SCLK] & filt_d[uart_cfg_pkg::PIN_SCLK]
			   & ~filt_q[uart_cfg_pkg::PIN_CS];
	assign sclk_fall = filt_q[uart_cfg_pkg::PIN_SCLK] & ~filt_d[uart_cfg_pkg::PIN_SCLK]
			   & ~filt_q[uart_cfg_pkg::PIN_CS];
	assign word_in   = {shift_q[14:0], filt_q[uart_cfg_pkg::PIN_DIN]};

	// input shifter, msb first, sampled on rising serial clock
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt_q <= 5'h00;
			shift_q   <= 16'h0000;
			frame_q   <= 16'h0000;
		end else if (cs_fall) begin
			bit_cnt_q <= 5'h00;
		end else if (sclk_rise) begin
			shift_q <= word_in;
			// extra edges spoil the frame: count runs past sixteen and saturates at 31
			if (bit_cnt_q != 5'h1f) begin
				bit_cnt_q <= bit_cnt_q + 5'h01;
			end
			if (bit_cnt_q == uart_cfg_pkg::FRAME_BITS - 5'h01) begin
				frame_q <= word_in;
			end
		end
	end

	// read-back image: pending setup wins so the host sees its last write
	always_comb begin
		readback = pend_valid_q ? pend_q : cfg_q; // see [R10]
		readback[uart_cfg_pkg::MASK_HI:uart_cfg_pkg::MASK_LO] = irq_mask;
		readback[uart_cfg_pkg::SLEEP_BIT] = sleep_state; // see [R14]
	end

	// reply word: flags taken at select fall, setup filled in once decoded
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reply_q <= 16'h0000;
		end else if (cs_fall) begin
			reply_q <= {rx_ready_flag, tx_empty_flag, 14'h0000}; // see [R6] see [R11] see [R12]
		end else if (sclk_rise && bit_cnt_q == uart_cfg_pkg::CMD_BITS - 5'h01
			     && word_in[1:0] == uart_cfg_pkg::CMD_READ_CFG) begin
			reply_q[13:0] <= readback; // see [R10]
		end
	end

	// output data: bit 15 driven at select fall, then bits 14 to 0 on falling serial clock
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dout       <= 1'b0;
			dout_oe    <= 1'b0;
			fall_cnt_q <= 4'h0;
		end else if (cs_fall) begin
			dout       <= rx_ready_flag;
			dout_oe    <= 1'b1;
			fall_cnt_q <= 4'h0;
		end else if (cs_rise) begin
			dout_oe <= 1'b0;
		end else if (sclk_fall && fall_cnt_q <= uart_cfg_pkg::LAST_FALL) begin
			dout       <= reply_q[uart_cfg_pkg::LAST_FALL - fall_cnt_q];
			fall_cnt_q <= fall_cnt_q + 4'h1;
		end
	end

	// masks act at the 16th rising edge of a write frame
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask <= uart_cfg_pkg::MASK_RESET;
		end else if (sclk_rise && bit_cnt_q == uart_cfg_pkg::FRAME_BITS - 5'h01
			     && word_in[15:14] == uart_cfg_pkg::CMD_WRITE_CFG) begin
			irq_mask <= word_in[uart_cfg_pkg::MASK_HI:uart_cfg_pkg::MASK_LO]; // see [R23]
		end
	end

	// other fields wait for the transmitter; held pending meanwhile
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pend_q       <= uart_cfg_pkg::CFG_RESET;
			pend_valid_q <= 1'b0;
			cfg_q        <= uart_cfg_pkg::CFG_RESET;
			cfg_clear    <= 1'b0;
		end else begin
			cfg_clear <= 1'b0;
			if (cs_rise && bit_cnt_q == uart_cfg_pkg::FRAME_BITS
			    && frame_q[15:14] == uart_cfg_pkg::CMD_WRITE_CFG) begin // see [R25]
				pend_q       <= frame_q[13:0];
				pend_valid_q <= 1'b1;
				cfg_clear    <= 1'b1; // see [R24]
			end else if (pend_valid_q && !tx_busy) begin
				cfg_q        <= pend_q; // see [R23]
				pend_valid_q <= 1'b0;
			end
		end
	end

	// field outputs of the applied setup
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fifo_off       <= 1'b0;
			sleep_state    <= 1'b0;
			infrared_sel   <= 1'b0;
			two_stop_sel   <= 1'b0;
			parity_on      <= 1'b0;
			short_word_sel <= 1'b0;
			divisor_code   <= 4'h0;
		end else begin
			fifo_off       <= cfg_q[uart_cfg_pkg::FIFO_OFF_BIT]; // see [R13]
			sleep_state    <= cfg_q[uart_cfg_pkg::SLEEP_BIT]; // see [R14]
			infrared_sel   <= cfg_q[uart_cfg_pkg::IR_BIT]; // see [R15]
			two_stop_sel   <= cfg_q[uart_cfg_pkg::STOP2_BIT]; // see [R16]
			parity_on      <= cfg_q[uart_cfg_pkg::PARITY_ON_BIT]; // see [R17]
			short_word_sel <= cfg_q[uart_cfg_pkg::SHORT_BIT]; // see [R5]
			divisor_code   <= cfg_q[uart_cfg_pkg::DIV_HI:0]; // see [R18]
		end
	end

	// test mode follows bit 0 of every complete read-back frame
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			test_mode <= 1'b0;
		end else if (cs_rise && bit_cnt_q == uart_cfg_pkg::FRAME_BITS
			     && frame_q[15:14] == uart_cfg_pkg::CMD_READ_CFG) begin
			test_mode <= frame_q[uart_cfg_pkg::TEST_BIT]; // see [R19]
		end
	end

	// interrupt sources in mask-bit order: tx empty, rx data, parity, activity
	assign sources = {tx_empty_flag, rx_ready_flag, parity_seen, rxact_ferr};

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_mask & sources); // see [R1] see [R2] see [R3] see [R4] see [R26]
		end
	end

	baud_tick_gen #(
		.HALF_CYCLES (OSC_HALF_CYCLES)
	) u_baud (
		.clock        (clock),
		.rst_n        (rst_n),
		.divisor_code (divisor_code),
		.baud16       (baud16)
	);

	// test pins only while select is low; otherwise the uart drives them
	assign test_drive = test_mode & ~filt_q[uart_cfg_pkg::PIN_CS];

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_pin    <= 1'b1;
			rts_n_pin <= 1'b1;
		end else begin
			tx_pin    <= test_drive ? 1'b0 : tx_line_in; // see [R21]
			rts_n_pin <= test_drive ? baud16 : rts_n_in; // see [R20]
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	a_irq_or_sources: assert property ( // see [R26]
		|(irq_mask & sources) |=> irq)
		else $error("irq missing for an enabled source");
	a_irq_masked_off: assert property ( // see [R1]
		(irq_mask & sources) == 4'h0 |=> !irq)
		else $error("irq raised with all sources masked");
	a_tx_test_low: assert property ( // see [R21]
		test_drive |=> !tx_pin)
		else $error("tx not low in test mode");
	a_rts_test_clock: assert property ( // see [R20]
		test_drive |=> rts_n_pin == $past(baud16))
		else $error("rts not carrying baud clock in test mode");
	a_write_reply_flags: assert property ( // see [R6]
		cs_fall |=> reply_q == {$past(rx_ready_flag), $past(tx_empty_flag), 14'h0000})
		else $error("write reply not flags plus zeros");
	a_mask_at_sixteen: assert property ( // see [R23]
		sclk_rise && bit_cnt_q == 5'h0f && word_in[15:14] == 2'h3
		|=> irq_mask == $past(word_in[11:8]))
		else $error("mask bits not taken at 16th edge");
	a_cfg_waits_busy: assert property ( // see [R23]
		pend_valid_q && tx_busy && !cs_rise |=> $stable(cfg_q))
		else $error("setup changed during transmission");
	a_cfg_applies: assert property ( // see [R23]
		pend_valid_q && !tx_busy && !cs_rise |=> cfg_q == $past(pend_q) && !pend_valid_q)
		else $error("pending setup not applied when idle");
	a_clear_pulse: assert property ( // see [R24]
		cfg_clear |=> !cfg_clear)
		else $error("clear pulse longer than one cycle");
	a_test_enter: assert property ( // see [R19]
		cs_rise && bit_cnt_q == 5'h10 && frame_q[15:14] == 2'h1
		|=> test_mode == $past(frame_q[0]))
		else $error("test mode not following read-back bit 0");
	a_short_frame_drop: assert property ( // see [R25]
		cs_rise && bit_cnt_q != 5'h10 |=> !cfg_clear && $stable(test_mode))
		else $error("incomplete frame acted on");
	a_readback_load: assert property ( // see [R10]
		sclk_rise && bit_cnt_q == 5'h01 && word_in[1:0] == 2'h1 && !cs_fall
		|=> reply_q[13:0] == $past(readback))
		else $error("read-back reply not loaded");

	c_write_frame: cover property (cfg_clear);
	c_read_frame: cover property (cs_rise && bit_cnt_q == 5'h10 && frame_q[15:14] == 2'h1);
	c_test_drive: cover property (test_drive ##1 rts_n_pin != $past(rts_n_pin));
	c_irq_raised: cover property (!irq ##1 irq);
endmodule // uart_config_port
